//--- design/event_user_mux_defs.svh
// Purpose: Offsets, reset values and consumer numbering of the event user mux
// Assumes: Register index n sits at byte address 4*n on the bus
// Notes:   Definitions only
`ifndef EVENT_USER_MUX_DEFS_SVH
`define EVENT_USER_MUX_DEFS_SVH

// Selection registers: index = base + consumer id
`define SEL_BASE_IDX      7'h20
`define SEL_RESET         8'h00
`define SEL_OFF           8'h00
`define NUM_USERS         43
// Live consumer event levels, read only
`define STATE_LO_IDX      7'h10
`define STATE_HI_IDX      7'h11
// Consumer id ranges
`define ID_LOGIC_FIRST    6'h00
`define ID_LOGIC_LAST     6'h0b
`define ID_UNUSED_A       6'h14
`define ID_SERIAL_FIRST   6'h15
`define ID_SERIAL_LAST    6'h19
`define ID_UNUSED_B       6'h1a
`define ID_TIMER_A_FIRST  6'h1b
`define ID_TIMER_A_LAST   6'h1e
`define ID_TIMER_B_FIRST  6'h1f
`define ID_TIMER_B_LAST   6'h28
`define NUM_TIMER_B       5

`endif

//--- design/event_user_mux_pkg.sv
// Purpose: Types shared by the event user mux files
// Assumes: Nothing beyond the defs header
// Notes:   Types only; numbers live in the defs header
package event_user_mux_pkg;

    typedef logic [7:0] sel_t;

    typedef enum logic [1:0]
    {
        DELIVER_NONE  = 2'b00,
        DELIVER_ASYNC = 2'b01,
        DELIVER_SYNC  = 2'b11,
        DELIVER_MODE  = 2'b10
    } delivery_t;

    typedef enum logic [1:0]
    {
        BUS_IDLE   = 2'b00,
        BUS_ANSWER = 2'b01
    } bus_state_t;

endpackage

//--- design/channel_fanout_if.sv
// Purpose: Carries the event channel levels from the top to every selector
// Assumes: One shared instance; all selectors read the same wires
// Notes:   Clock and reset travel along for the synchronous path
`timescale 1ns/100ps
`default_nettype none

interface channel_fanout_if #(parameter int NUM_CHANNELS = 16);
    logic                    clk;
    logic                    rst_b;
    logic [NUM_CHANNELS-1:0] channel;

    modport source (output clk, output rst_b, output channel);
    modport user   (input clk, input rst_b, input channel);
endinterface

`default_nettype wire

//--- design/event_user_select.sv
// Purpose: Picks one event channel, or none, for a single consumer
// Assumes: Selection value is held in a flip-flop by the caller
// Notes:   Values above the channel count connect nothing
`include "event_user_mux_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module event_user_select
    import event_user_mux_pkg::*;
#(
    parameter int NUM_CHANNELS = 16
)
(
    // Shared channel levels
    channel_fanout_if.user fan,
    // Control
    input  wire sel_t      sel,
    input  wire logic      sync_mode,
    // Event to the consumer
    output logic           evt
);

    logic picked;
    logic picked_q;

    always_comb
    begin
        picked = 1'b0;
        if (sel != `SEL_OFF && 32'(sel) <= NUM_CHANNELS)
        begin
            picked = fan.channel[32'(sel) - 1];
        end
    end

    always_ff @(posedge fan.clk or negedge fan.rst_b)
    begin
        if (!fan.rst_b)
        begin
            picked_q <= 1'b0;
        end
        else
        begin
            picked_q <= picked;
        end
    end

    // Async users see the channel without a clock stage
    assign evt = sync_mode ? picked_q : picked;

endmodule

`default_nettype wire

//--- design/event_user_mux.sv
// Purpose: Routes event channels to 43 consumer event inputs
// Assumes: Avalon-MM slave with waitrequest, byte addresses, one word per register
// Notes:   Asynchronous consumers bypass all flops, so their outputs are combinational
`include "event_user_mux_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module event_user_mux
    import event_user_mux_pkg::*;
#(
    parameter int NUM_CHANNELS = 16,
    parameter int ADDR_W       = 9
)
(
    // Clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    rst_b,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0]       avs_address,
    input  wire logic                    avs_read,
    input  wire logic                    avs_write,
    input  wire logic [31:0]             avs_writedata,
    input  wire logic [3:0]              avs_byteenable,
    output logic [31:0]                  avs_readdata,
    output logic                         avs_waitrequest,
    // Event channels in
    input  wire logic [NUM_CHANNELS-1:0] channel_event,
    // Type B timer capture mode, high for async delivery
    input  wire logic [`NUM_TIMER_B-1:0] capture_async_mode,
    // Consumer event inputs out, indexed by consumer id
    output logic [`NUM_USERS-1:0]        consumer_event
);

    ////////////////////////////////////////////////////////////////////////////////
    // Elaboration checks

    if (NUM_CHANNELS < 1 || NUM_CHANNELS > 255)
    begin : bad_channels
        $error("NUM_CHANNELS must lie in 1..255");
    end
    if (ADDR_W < 9)
    begin : bad_addr_w
        $error("ADDR_W too small for the register map");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Consumer classification

    // Delivery of each consumer id
    function automatic delivery_t delivery_of(input logic [5:0] id);
        delivery_t d;
        d = DELIVER_ASYNC;
        if (id == `ID_UNUSED_A || id == `ID_UNUSED_B)
        begin
            d = DELIVER_NONE;
        end
        else if (id >= `ID_LOGIC_FIRST && id <= `ID_LOGIC_LAST)
        begin
            d = DELIVER_ASYNC;
        end
        else if (id >= `ID_SERIAL_FIRST && id <= `ID_SERIAL_LAST)
        begin
            d = DELIVER_SYNC;
        end
        else if (id >= `ID_TIMER_A_FIRST && id <= `ID_TIMER_A_LAST)
        begin
            d = DELIVER_SYNC;
        end
        else if (id >= `ID_TIMER_B_FIRST && id <= `ID_TIMER_B_LAST)
        begin
            d = id[0] ? DELIVER_MODE : DELIVER_SYNC;
        end
        return d;
    endfunction

    // Type B timer that owns a capture id
    function automatic logic [2:0] timer_b_of(input logic [5:0] id);
        logic [5:0] off;
        off = id - `ID_TIMER_B_FIRST;
        return off[3:1];
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode

    function automatic logic is_sel_index(input logic [6:0] idx);
        return idx >= `SEL_BASE_IDX && 32'(idx) < 32'(`SEL_BASE_IDX) + `NUM_USERS;
    endfunction

    logic [6:0] word_idx;
    logic [5:0] user_idx;
    logic       request;

    assign word_idx = avs_address[8:2];
    assign user_idx = 6'(word_idx - `SEL_BASE_IDX);
    assign request  = avs_read || avs_write;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus handshake

    // Every access costs two edges: one to fetch, one to finish.
    // The fixed spacing keeps readdata a plain flop at the cost of throughput.
    bus_state_t bus_state;
    logic       take;

    assign take = request && bus_state == BUS_ANSWER;

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bus_state <= BUS_IDLE;
        end
        else
        begin
            case (bus_state)
                BUS_IDLE:
                begin
                    if (request)
                    begin
                        bus_state <= BUS_ANSWER;
                    end
                end
                BUS_ANSWER:
                begin
                    bus_state <= BUS_IDLE;
                end
                default:
                begin
                    bus_state <= BUS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            avs_waitrequest <= 1'b1;
        end
        else
        begin
            avs_waitrequest <= !(request && bus_state == BUS_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Selection registers

    sel_t sel_reg [`NUM_USERS];

    // Only the low byte lane holds data; other lanes are ignored
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < `NUM_USERS; i++)
            begin
                sel_reg[i] <= `SEL_RESET;
            end
        end
        else if (take && avs_write && avs_byteenable[0] && is_sel_index(word_idx))
        begin
            sel_reg[user_idx] <= avs_writedata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data

    logic [31:0] next_readdata;
    logic [63:0] state_wide;

    assign state_wide = {{(64 - `NUM_USERS){1'b0}}, consumer_event};

    always_comb
    begin
        next_readdata = 32'h0000_0000;
        if (is_sel_index(word_idx))
        begin
            next_readdata = {24'h00_0000, sel_reg[user_idx]};
        end
        else if (word_idx == `STATE_LO_IDX)
        begin
            next_readdata = state_wide[31:0];
        end
        else if (word_idx == `STATE_HI_IDX)
        begin
            next_readdata = state_wide[63:32];
        end
    end

    // Loaded on the fetch edge, held through the finishing edge
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            avs_readdata <= 32'h0000_0000;
        end
        else if (avs_read && bus_state == BUS_IDLE)
        begin
            avs_readdata <= next_readdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Channel fan-out

    channel_fanout_if #(.NUM_CHANNELS(NUM_CHANNELS)) fan ();

    assign fan.clk     = sys_clk;
    assign fan.rst_b   = rst_b;
    assign fan.channel = channel_event;

    ////////////////////////////////////////////////////////////////////////////////
    // One selector per consumer

    genvar g;
    generate
        for (g = 0; g < `NUM_USERS; g++)
        begin : user
            localparam delivery_t KIND = delivery_of(6'(g));
            logic sync_mode;
            logic evt;

            if (KIND == DELIVER_MODE)
            begin : mode
                assign sync_mode = !capture_async_mode[timer_b_of(6'(g))];
            end
            else
            begin : fixed
                assign sync_mode = KIND == DELIVER_SYNC;
            end

            event_user_select #(.NUM_CHANNELS(NUM_CHANNELS)) sel_u
            (
                .fan       (fan),
                .sel       (sel_reg[g]),
                .sync_mode (sync_mode),
                .evt       (evt)
            );

            if (KIND == DELIVER_NONE)
            begin : idle
                assign consumer_event[g] = 1'b0;
            end
            else
            begin : live
                assign consumer_event[g] = evt;
            end
        end
    endgenerate

endmodule

`default_nettype wire

//--- bench/event_user_mux_assertions.sv
// Purpose: Port-level checks of the event user mux
// Assumes: Selection registers at word index 0x20 and up
// Notes:   Bound to every mux instance
`timescale 1ns/100ps
`default_nettype none

module event_user_mux_assertions
    import event_user_mux_pkg::*;
#(
    parameter int NUM_CHANNELS = 16,
    parameter int ADDR_W       = 9
)
(
    // Clock and bus
    input wire logic                    sys_clk,
    input wire logic                    rst_b,
    input wire logic [ADDR_W-1:0]       avs_address,
    input wire logic                    avs_read,
    input wire logic                    avs_write,
    input wire logic [31:0]             avs_readdata,
    input wire logic                    avs_waitrequest,
    // Events
    input wire logic [NUM_CHANNELS-1:0] channel_event,
    input wire logic [4:0]              capture_async_mode,
    input wire logic [42:0]             consumer_event
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    chk_req_answered: assert property ((avs_read || avs_write) && avs_waitrequest
        |-> ##[1:2] !avs_waitrequest) else $error("bus request not answered");
    chk_sel_hi_zero: assert property (avs_read && !avs_waitrequest
        && avs_address[8:2] >= 7'h20 |-> avs_readdata[31:8] == 24'h0)
        else $error("selection read has high bits set");
    chk_reset_all_off: assert property ($rose(rst_b) |-> consumer_event == 43'h0)
        else $error("consumer active right after reset");
    chk_unused_quiet: assert property (!consumer_event[20] && !consumer_event[26])
        else $error("unassigned consumer driven");
    chk_async_idle: assert property (channel_event == '0
        |-> consumer_event[19:0] == 20'h0 && consumer_event[42:41] == 2'h0)
        else $error("async consumer high without a channel");
    chk_sync_latency: assert property ($past(channel_event) == '0
        |-> consumer_event[30:21] == 10'h0) else $error("sync consumer without latency");
    chk_count_sync: assert property ($past(channel_event) == '0 |-> {consumer_event[40],
        consumer_event[38], consumer_event[36], consumer_event[34], consumer_event[32]} == 5'h0)
        else $error("count input without latency");
    chk_capture_mode: assert property (channel_event == '0 && capture_async_mode[0]
        |-> !consumer_event[31]) else $error("async capture input not combinational");

    cover property (avs_write && !avs_waitrequest);
    cover property ($rose(consumer_event[31]));
    cover property ($rose(consumer_event[42]));
endmodule

bind event_user_mux event_user_mux_assertions #(
    .NUM_CHANNELS(NUM_CHANNELS),
    .ADDR_W(ADDR_W)
) event_user_mux_assertions_inst (.sys_clk(sys_clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .channel_event(channel_event), .capture_async_mode(capture_async_mode),
    .consumer_event(consumer_event));

`default_nettype wire

//--- bench/event_channel_source.sv
// Purpose: Event channel network feeding the mux
// Assumes: Generators run on sys_clk
// Notes:   Levels launch just after an edge, like real sync generators
`timescale 1ns/100ps
`default_nettype none

module event_channel_source
#(
    parameter int NUM_CHANNELS = 16
)
(
    // Clock
    input  wire logic                    sys_clk,
    // Wanted levels and channel lines
    input  wire logic [NUM_CHANNELS-1:0] want,
    output logic [NUM_CHANNELS-1:0]      channel_event
);
    always_ff @(posedge sys_clk)
        channel_event <= want;
endmodule

`default_nettype wire

//--- bench/testbench.sv
// Purpose: Self-checking bench of the event user mux
// Assumes: 16 channels, 25 ns clock
// Notes:   Expected routing is rebuilt from selections i%16+1
`timescale 1ns/100ps
`default_nettype none

module testbench
    import event_user_mux_pkg::*;
;
    logic        sys_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [8:0]  avs_address = 9'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [15:0] want = 16'h0;
    logic [15:0] channel_event;
    logic [4:0]  capture_async_mode = 5'h0;
    logic [42:0] consumer_event;
    logic [31:0] rd;
    logic [15:0] prev = 16'h0;
    int          n_mismatch = 0;
    int          checks_done = 0;

    initial forever #12.5 sys_clk = ~sys_clk;

    event_channel_source #(.NUM_CHANNELS(16)) event_channel_source_inst (.sys_clk(sys_clk),
        .want(want), .channel_event(channel_event));
    event_user_mux #(.NUM_CHANNELS(16), .ADDR_W(9)) event_user_mux_inst (.sys_clk(sys_clk),
        .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .channel_event(channel_event),
        .capture_async_mode(capture_async_mode), .consumer_event(consumer_event));

////////////////////////////////////////
    task automatic chk(input string nm, input logic [42:0] exp, input logic [42:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic bus(input logic wr, input logic [6:0] idx, input logic [7:0] d,
                       input logic [3:0] be);
        @(posedge sys_clk);
        avs_address    <= {idx, 2'b00};
        avs_read       <= !wr;
        avs_write      <= wr;
        avs_writedata  <= {24'h0, d};
        avs_byteenable <= be;
        // Only the watchdog ends a wait that never sees waitrequest low
        do
        begin
            @(posedge sys_clk);
        end
        while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // Sync consumers still show the old level one cycle after a channel change
    function automatic logic [42:0] expect_ce(input logic [15:0] now, input logic [15:0] old);
        logic [42:0] e;
        logic        s;
        for (int i = 0; i < 43; i++)
        begin
            s = i >= 21 && i <= 40 && !(i % 2 == 1 && i >= 31 && capture_async_mode[(i-31)/2]);
            e[i] = (i == 20 || i == 26) ? 1'b0 : (s ? old[i%16] : now[i%16]);
        end
        return e;
    endfunction

////////////////////////////////////////
    task automatic reset_values();
        for (int i = 0; i < 43; i++)
        begin
            bus(1'b0, 7'h20 + 7'(i), 8'h0, 4'hf);
            chk("sel reset", 43'h0, 43'(rd));
        end
        bus(1'b0, 7'h7f, 8'h0, 4'hf);
        chk("unmapped read", 43'h0, 43'(rd));
    endtask

    // Id 2 gets a write with its lane disabled, which must not land
    task automatic write_readback();
        for (int i = 0; i < 43; i++)
            bus(1'b1, 7'h20 + 7'(i), 8'(i % 16 + 1), 4'h1);
        bus(1'b1, 7'h22, 8'h0, 4'h0);
        bus(1'b1, 7'h4b, 8'h5, 4'h1);
        for (int i = 0; i < 43; i++)
        begin
            bus(1'b0, 7'h20 + 7'(i), 8'h0, 4'hf);
            chk("sel readback", 43'(i % 16 + 1), 43'(rd));
        end
        bus(1'b0, 7'h4b, 8'h0, 4'hf);
        chk("past last id", 43'h0, 43'(rd));
    endtask

    task automatic route(input logic [4:0] mode);
        logic [15:0] pat [4] = '{16'ha5c3, 16'h0, 16'hffff, 16'h5a3c};
        logic [42:0] e;
        @(posedge sys_clk);
        capture_async_mode <= mode;
        foreach (pat[k])
        begin
            @(posedge sys_clk);
            want <= pat[k];
            @(posedge sys_clk);
            @(negedge sys_clk);
            chk("events now", expect_ce(pat[k], prev), consumer_event);
            @(negedge sys_clk);
            chk("events later", expect_ce(pat[k], pat[k]), consumer_event);
            prev = pat[k];
            e = expect_ce(pat[k], pat[k]);
            bus(1'b0, 7'h10, 8'h0, 4'hf);
            chk("state low", 43'(e[31:0]), 43'(rd));
            bus(1'b0, 7'h11, 8'h0, 4'hf);
            chk("state high", 43'(e[42:32]), 43'(rd));
        end
    endtask

    task automatic disconnect();
        @(posedge sys_clk);
        want <= 16'hffff;
        repeat (3) @(posedge sys_clk);
        bus(1'b1, 7'h20, 8'h0, 4'h1);
        @(negedge sys_clk);
        chk("id 0 off", 43'h0, 43'(consumer_event[0]));
        bus(1'b1, 7'h35, 8'h0, 4'h1);
        bus(1'b1, 7'h21, 8'h11, 4'h1);
        repeat (2) @(negedge sys_clk);
        chk("ids 21 and 1 off", 43'h0, 43'({consumer_event[21], consumer_event[1]}));
    endtask

////////////////////////////////////////
    task automatic tally_and_finish();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        repeat (20) @(posedge sys_clk);
        rst_b <= 1'b1;
        reset_values();
        write_readback();
        route(5'b10101);
        route(5'b01010);
        disconnect();
        tally_and_finish();
    end

    // About 150 accesses of 3 cycles each; ample margin before calling it a hang
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        n_mismatch++;
        tally_and_finish();
    end
endmodule

`default_nettype wire
